// [hw/timer_wakeup.sv]
// Timer with low-power wake-up path and mode-to-pin assignment.
// Assumes clock is the always-on timer clock and an Avalon-MM master.
// Operation
// - Counting continues while system clock stopped
// - Enabled timer event raises wake request
// - No wake request unless wake enable set
// - Wake flag register shows timer caused wake
// - Lower-half event sets lower irq; any event sets wake status if wake enable set
// - Modes 0,1,5 drive primary and inverted outputs
// - Reduced instances have no inverted outputs
// - Mode codes decoded; reserved codes stay idle
// - Input modes use the half's pin
`timescale 1ns/1ps
module timer_wakeup
  import twk_pkg::*;
#(
  parameter bit FULL_FEATURE = 1'b1,
  parameter int LP_INDEX     = 0,
  parameter int RDY_CYC      = CLK_RDY_CYC
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clock_en,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        lower_half_pin_i,
  output logic             lower_half_pin_o,
  output logic             lower_half_pin_oe_n,
  input  wire logic        upper_half_pin_i,
  output logic             upper_half_pin_o,
  output logic             upper_half_pin_oe_n,
  output logic             lower_half_inverted_pin,
  output logic             lower_half_inverted_pin_oe_n,
  output logic             upper_half_inverted_pin,
  output logic             upper_half_inverted_pin_oe_n,
  output logic             irq,
  output logic             wake_req
);
  typedef struct packed {
    logic                   wreq;
    logic [31:0]            rdata;
    logic                   en;
    logic                   we;
    logic                   outen;
    logic                   outben;
    logic [MODE_W-1:0]      mode;
    logic [RDY_W-1:0]       rdy_cnt;
    logic                   clk_rdy;
    logic [1:0][HALF_W-1:0] cmp;
    logic [1:0][HALF_W-1:0] cnt;
    logic [1:0][HALF_W-1:0] cap;
    logic [1:0]             out_lvl;
    logic [1:0]             pin_oe_n;
    logic [1:0]             inv_o;
    logic [1:0]             inv_oe_n;
    logic                   wkfl;
    logic [1:0]             lpst;
    logic [1:0]             lpen;
    logic [IRQ_W-1:0]       irq_st;
    logic [IRQ_W-1:0]       irq_mask;
    logic                   irq;
    logic                   wake_req;
  } core_t;

  core_t       s;
  core_t       next_s;
  logic [1:0]  ev;
  logic [1:0]  tick;
  logic [1:0]  cap_ev;
  logic [31:0] rd;
  logic [31:0] wm;
  logic        bus_wr;

  pin_sync_if pins ();

  // Byte-enable mask of a write
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  // Merge enabled bytes of write data into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    return (old & ~be_mask(be)) | (wd & be_mask(be));
  endfunction : merge

  // Modes that drive the timer pins
  function automatic logic is_out(input logic [3:0] m);
    return (m == MODE_ONESHOT) || (m == MODE_CONT) || (m == MODE_COMPARE);
  endfunction : is_out

  // Modes that take their events from the timer pins
  function automatic logic is_in(input logic [3:0] m);
    return (m == MODE_COUNTER) || (m == MODE_CAPTURE) || (m == MODE_GATED) ||
           (m == MODE_CAPCMP) || (m == MODE_DUALCAP) || (m == MODE_INGATED);
  endfunction : is_in

  pin_sync u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .clock_en (clock_en),
    .raw      ({upper_half_pin_i, lower_half_pin_i}),
    .sync     (pins.producer)
  );

  // Write accepted at the edge where waitrequest is low
  assign bus_wr = avs_write && !s.wreq;
  assign wm     = avs_writedata & be_mask(avs_byteenable);

  // Next-state logic
  always_comb begin
    next_s = s;
    ev     = 2'b00;
    tick   = 2'b00;
    cap_ev = 2'b00;
    rd     = RD_UNMAPPED;

    // Clock ready rises a fixed time after enable
    if (!s.en) begin
      next_s.rdy_cnt = '0;
      next_s.clk_rdy = 1'b0;
    end else if (!s.clk_rdy) begin
      if (s.rdy_cnt == RDY_W'(RDY_CYC - 1)) begin
        next_s.clk_rdy = 1'b1;
      end else begin
        next_s.rdy_cnt = s.rdy_cnt + 1'b1;
      end
    end

    // Both halves: count source, capture, period end, pins
    for (int h = 0; h < 2; h++) begin
      // Runs on own clock, no system clock needed
      if (s.en && s.clk_rdy) begin
        case (s.mode)
          MODE_ONESHOT, MODE_CONT, MODE_COMPARE: tick[h] = 1'b1;
          MODE_CAPTURE, MODE_CAPCMP, MODE_DUALCAP: tick[h] = 1'b1;
          MODE_COUNTER: tick[h] = pins.rise[h];
          MODE_GATED:   tick[h] = pins.level[h];
          MODE_INGATED: tick[h] = !pins.level[h];
          default:      tick[h] = 1'b0;
        endcase
        case (s.mode)
          MODE_CAPTURE, MODE_CAPCMP: cap_ev[h] = pins.rise[h];
          MODE_DUALCAP: cap_ev[h] = pins.rise[h] | pins.fall[h];
          default:      cap_ev[h] = 1'b0;
        endcase
      end
      if (cap_ev[h]) begin
        next_s.cap[h] = s.cnt[h];
        ev[h] = 1'b1;
        if (s.mode != MODE_CAPCMP) begin
          next_s.cnt[h] = CNT_RELOAD;
        end else begin
          next_s.cnt[h] = s.cnt[h] + 1'b1;
        end
      end else if (tick[h]) begin
        if (s.cnt[h] == s.cmp[h]) begin
          ev[h] = 1'b1;
          next_s.cnt[h] = (s.mode == MODE_COMPARE) ? s.cnt[h] + 1'b1 : CNT_RELOAD;
        end else begin
          next_s.cnt[h] = s.cnt[h] + 1'b1;
        end
      end
      // Output level: one-cycle pulse or toggle
      if (s.mode == MODE_ONESHOT) begin
        next_s.out_lvl[h] = ev[h];
      end else if (ev[h] && is_out(s.mode)) begin
        next_s.out_lvl[h] = !s.out_lvl[h];
      end
      next_s.pin_oe_n[h] = !(is_out(s.mode) && s.outen);
      next_s.inv_oe_n[h] = !(FULL_FEATURE && is_out(s.mode) && s.outben);
      next_s.inv_o[h]    = !next_s.out_lvl[h];
    end

    // One-shot disables itself at period end
    if ((s.mode == MODE_ONESHOT) && (|ev)) begin
      next_s.en = 1'b0;
    end

    // Read multiplexer, captured at the end of the wait cycle, one cycle before the request is answered
    case (avs_address)
      OFF_CTRL: begin
        rd[CTRL_EN]     = s.en;
        rd[CTRL_WE]     = s.we;
        rd[CTRL_OUTEN]  = s.outen;
        rd[CTRL_OUTBEN] = s.outben;
        rd[CTRL_MODE_LO +: MODE_W] = s.mode;
      end
      OFF_STAT: begin
        rd[STAT_RDY] = s.clk_rdy;
        rd[STAT_RUN] = s.en && s.clk_rdy;
      end
      OFF_CMP:      rd = s.cmp;
      OFF_CNT:      rd = s.cnt;
      OFF_CAP:      rd = s.cap;
      OFF_WKFL:     rd = {31'h0000_0000, s.wkfl};
      OFF_LPST:     rd = {30'h0000_0000, s.lpst};
      OFF_LPEN:     rd = {30'h0000_0000, s.lpen};
      OFF_IRQ_ST:   rd = {29'h0000_0000, s.irq_st};
      OFF_IRQ_MASK: rd = {29'h0000_0000, s.irq_mask};
      default:      rd = RD_UNMAPPED;
    endcase

    // Bus handshake: one wait cycle, then accept
    next_s.wreq = 1'b1;
    if ((avs_read || avs_write) && s.wreq) begin
      next_s.wreq  = 1'b0;
      next_s.rdata = rd;
    end

    // Register writes
    if (bus_wr) begin
      case (avs_address)
        OFF_CTRL: begin
          if (avs_byteenable[0]) begin
            next_s.en     = avs_writedata[CTRL_EN];
            next_s.we     = avs_writedata[CTRL_WE];
            next_s.outen  = avs_writedata[CTRL_OUTEN];
            next_s.outben = avs_writedata[CTRL_OUTBEN];
            // Mode only changes while the timer is stopped
            if (!s.en) begin
              next_s.mode = avs_writedata[CTRL_MODE_LO +: MODE_W];
            end
          end
        end
        OFF_CMP:      next_s.cmp      = merge(s.cmp, avs_writedata, avs_byteenable);
        OFF_CNT:      next_s.cnt      = merge(s.cnt, avs_writedata, avs_byteenable);
        OFF_WKFL:     next_s.wkfl     = s.wkfl & !wm[0];
        OFF_LPST:     next_s.lpst     = s.lpst & ~wm[1:0];
        OFF_LPEN:     next_s.lpen     = avs_byteenable[0] ? avs_writedata[1:0] : s.lpen;
        OFF_IRQ_ST:   next_s.irq_st   = s.irq_st & ~wm[IRQ_W-1:0];
        OFF_IRQ_MASK: next_s.irq_mask = avs_byteenable[0] ? avs_writedata[IRQ_W-1:0] : s.irq_mask;
        default: ;
      endcase
    end

    // Sticky event flags; a set wins over a same-cycle clear
    if (ev[0] || (!FULL_FEATURE && ev[1])) begin
      next_s.irq_st[IRQ_LO] = 1'b1;
    end
    if (FULL_FEATURE && ev[1]) begin
      next_s.irq_st[IRQ_HI] = 1'b1;
    end
    if ((|ev) && s.we) begin
      next_s.lpst[LP_INDEX]   = 1'b1;
      next_s.wkfl             = 1'b1;
      next_s.irq_st[IRQ_WAKE] = 1'b1;
    end

    // Wake request gated by matching enable, held until status clears
    next_s.wake_req = |(next_s.lpst & next_s.lpen);
    next_s.irq      = |(next_s.irq_st & next_s.irq_mask);
  end

  // State register; clock_en freezes everything
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s          <= '0;
      s.wreq     <= 1'b1;
      s.pin_oe_n <= 2'b11;
      s.inv_oe_n <= 2'b11;
      s.inv_o    <= 2'b11;
    end else if (clock_en) begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata                 = s.rdata;
  assign avs_waitrequest              = s.wreq;
  assign lower_half_pin_o             = s.out_lvl[0];
  assign lower_half_pin_oe_n          = s.pin_oe_n[0];
  assign upper_half_pin_o             = s.out_lvl[1];
  assign upper_half_pin_oe_n          = s.pin_oe_n[1];
  assign lower_half_inverted_pin      = s.inv_o[0];
  assign lower_half_inverted_pin_oe_n = s.inv_oe_n[0];
  assign upper_half_inverted_pin      = s.inv_o[1];
  assign upper_half_inverted_pin_oe_n = s.inv_oe_n[1];
  assign irq                          = s.irq;
  assign wake_req                     = s.wake_req;

  // Checks on wake path and pin assignment
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence wake_cause;
    (|ev) && s.we && clock_en && !bus_wr;
  endsequence

  sequence rdy_wait;
    s.en && $past(s.en) && $past(s.en, 2);
  endsequence

  a_wake_needs_enable: assert property ($rose(wake_req) |-> $past(s.we) || $past(bus_wr))
    else $error("wake request rose without wake enable");

  a_wake_rises: assert property (wake_cause and s.lpen[LP_INDEX] |=> wake_req && s.wkfl)
    else $error("enabled event did not raise wake request");

  a_wake_held: assert property ($fell(wake_req) |-> $past(bus_wr))
    else $error("wake request dropped without software clear");

  a_wake_flag: assert property (wake_cause |=> s.wkfl && s.lpst[LP_INDEX])
    else $error("wake flag not set by event");

  a_lower_irq: assert property (ev[0] && clock_en |=> s.irq_st[IRQ_LO])
    else $error("lower-half interrupt flag not set");

  a_ready_delay: assert property ($rose(s.clk_rdy) |-> rdy_wait)
    else $error("clock ready rose too early");

  a_count_gated: assert property ($changed(s.cnt) |-> $past(s.clk_rdy) || $past(bus_wr))
    else $error("counter moved without clock ready");

  a_oneshot_stop: assert property ((s.mode == MODE_ONESHOT) && (|ev) && clock_en && !bus_wr |=> !s.en)
    else $error("one-shot did not stop at period end");

  a_inv_reduced: assert property (!FULL_FEATURE |-> (s.inv_oe_n == 2'b11))
    else $error("reduced instance drove an inverted pin");

  a_inv_complement: assert property (!s.inv_oe_n[1] |-> s.inv_o[1] != s.out_lvl[1])
    else $error("inverted output not complementary");

  a_input_no_drive: assert property (is_in(s.mode) && clock_en |=> (s.pin_oe_n == 2'b11))
    else $error("input mode drove a timer pin");

  a_mode_locked: assert property (s.en |=> $stable(s.mode))
    else $error("mode changed while timer running");

  a_wake_gated: assert property (!s.we |=> !$rose(s.wkfl))
    else $error("wake flag set without wake enable");

  a_irq_level: assert property (irq == |(s.irq_st & s.irq_mask))
    else $error("interrupt output does not follow masked status");
endmodule : timer_wakeup

// [include/twk_pkg.sv]
// Constants for the timer wake-up and mode-to-pin block.
// Assumes Avalon-MM byte addressing with 32-bit aligned registers.
package twk_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STAT     = 8'h04;
  localparam logic [7:0] OFF_CMP      = 8'h08;
  localparam logic [7:0] OFF_CNT      = 8'h0c;
  localparam logic [7:0] OFF_CAP      = 8'h10;
  localparam logic [7:0] OFF_WKFL     = 8'h14;
  localparam logic [7:0] OFF_LPST     = 8'h18;
  localparam logic [7:0] OFF_LPEN     = 8'h1c;
  localparam logic [7:0] OFF_IRQ_ST   = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  // Control word fields
  localparam int CTRL_EN      = 0;
  localparam int CTRL_WE      = 1;
  localparam int CTRL_OUTEN   = 2;
  localparam int CTRL_OUTBEN  = 3;
  localparam int CTRL_MODE_LO = 4;
  localparam int MODE_W       = 4;
  // Status word fields
  localparam int STAT_RDY = 0;
  localparam int STAT_RUN = 1;
  // Interrupt status bits
  localparam int IRQ_LO   = 0;
  localparam int IRQ_HI   = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_W    = 3;
  // Mode codes
  localparam logic [3:0] MODE_ONESHOT = 4'h0;
  localparam logic [3:0] MODE_CONT    = 4'h1;
  localparam logic [3:0] MODE_COUNTER = 4'h2;
  localparam logic [3:0] MODE_CAPTURE = 4'h4;
  localparam logic [3:0] MODE_COMPARE = 4'h5;
  localparam logic [3:0] MODE_GATED   = 4'h6;
  localparam logic [3:0] MODE_CAPCMP  = 4'h7;
  localparam logic [3:0] MODE_DUALCAP = 4'h8;
  localparam logic [3:0] MODE_INGATED = 4'he;
  // Counter values and timing
  localparam int          HALF_W      = 16;
  localparam logic [15:0] CNT_RELOAD  = 16'h0001;
  localparam int          RDY_W       = 4;
  localparam int          CLK_RDY_CYC = 2;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage : twk_pkg

// [include/pin_sync_if.sv]
// Carrier for synchronised timer pin levels and edges.
// Assumes one producer (pin synchroniser) and one consumer (timer core).
`timescale 1ns/1ps
interface pin_sync_if;
  logic [1:0] level;
  logic [1:0] rise;
  logic [1:0] fall;
  modport producer (output level, output rise, output fall);
  modport consumer (input level, input rise, input fall);
endinterface : pin_sync_if

// [hw/pin_sync.sv]
// Three-stage synchroniser for the two timer input pins.
// Assumes pins are asynchronous to clock; clock_en freezes all stages.
`timescale 1ns/1ps
module pin_sync
  import twk_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic clock_en,
  input  wire logic [1:0] raw,
  pin_sync_if.producer sync
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
  } sync_t;

  sync_t s;
  sync_t next_s;

  // Shift chain; level accepted once stages two and three agree
  always_comb begin
    next_s     = s;
    next_s.s1  = raw;
    next_s.s2  = s.s1;
    next_s.s3  = s.s2;
    for (int h = 0; h < 2; h++) begin
      if (s.s2[h] == s.s3[h]) begin
        next_s.lvl[h] = s.s3[h];
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else if (clock_en) begin
      s <= next_s;
    end
  end

  // Edge pulses last one enabled cycle
  assign sync.level = s.lvl;
  assign sync.rise  = ~s.lvl & s.s3 & ~(s.s2 ^ s.s3);
  assign sync.fall  = s.lvl & ~s.s3 & ~(s.s2 ^ s.s3);
endmodule : pin_sync

// [verif/power_mgr_model.sv]
// Behavioural power manager and clock control beside the timer block.
// Assumes wake_req is a level in the same always-on clock domain.
`timescale 1ns/1ps
module power_mgr_model (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic sleep_req,
  input  wire logic wake_req,
  output logic      sys_clk_on
);
  // System clock gate: off on sleep, back on at wake
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sys_clk_on <= 1'b1;
    end else if (wake_req) begin
      sys_clk_on <= 1'b1;
    end else if (sleep_req) begin
      sys_clk_on <= 1'b0;
    end
  end
endmodule : power_mgr_model

// [verif/tb_top.sv]
// Self-checking bench for the timer wake-up and mode-to-pin block.
// Assumes one 100 MHz clock and an Avalon-MM master driven here.
`timescale 1ns/1ps
module tb_top;
  import twk_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pin_lo = 1'b0;
  logic        pin_hi = 1'b0;
  logic        sleep_req = 1'b0;
  logic        lo_o, lo_oe_n, hi_o, hi_oe_n, lo_inv, lo_inv_oe_n;
  logic        hi_inv, hi_inv_oe_n, irq, wake_req, sys_clk_on;
  logic [31:0] rv;
  int          err_count = 0;
  int          check_count = 0;
  localparam int LP_INDEX = 0;

  // Free-running clock
  always #5 clock = ~clock;

  timer_wakeup #(.LP_INDEX(LP_INDEX)) timer_wakeup_i (
    .clock(clock), .sys_rst(sys_rst), .clock_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lower_half_pin_i(pin_lo), .lower_half_pin_o(lo_o), .lower_half_pin_oe_n(lo_oe_n),
    .upper_half_pin_i(pin_hi), .upper_half_pin_o(hi_o), .upper_half_pin_oe_n(hi_oe_n),
    .lower_half_inverted_pin(lo_inv), .lower_half_inverted_pin_oe_n(lo_inv_oe_n),
    .upper_half_inverted_pin(hi_inv), .upper_half_inverted_pin_oe_n(hi_inv_oe_n),
    .irq(irq), .wake_req(wake_req));

  power_mgr_model power_mgr_model_i (
    .clock(clock), .sys_rst(sys_rst), .sleep_req(sleep_req),
    .wake_req(wake_req), .sys_clk_on(sys_clk_on));

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One Avalon-MM transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data, output logic [31:0] rd);
    int n;
    avs_address   <= addr;
    avs_writedata <= data;
    avs_read      <= !wr;
    avs_write     <= wr;
    // Sampled at each rising edge; data taken at the edge with waitrequest low
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      err_count++;
      results();
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : bus

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    bus(1'b1, addr, data, d);
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [31:0] data);
    bus(1'b0, addr, 32'h0, data);
  endtask : rd

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    rd(addr, d);
    check(d, exp);
  endtask : rd_chk

  // Configure while disabled, then enable and poll clock ready
  task automatic start(input logic [7:0] ctrl);
    logic [31:0] d;
    int n;
    wr(OFF_CTRL, {24'h0, ctrl[7:1], 1'b0});
    wr(OFF_CTRL, {24'h0, ctrl});
    for (n = 0; n < 20; n++) begin
      rd(OFF_STAT, d);
      if (d[STAT_RDY] === 1'b1) break;
    end
    check({31'h0, d[STAT_RDY]}, 32'h1);
    if (n == 20) results();
  endtask : start

  // Bounded wait for a wake request level
  task automatic wait_wake(input logic lvl);
    int n;
    for (n = 0; n < 200 && wake_req !== lvl; n++) @(posedge clock);
    check({31'h0, wake_req}, {31'h0, lvl});
    if (n == 200) results();
  endtask : wait_wake

  // Reset levels and unmapped access
  task automatic t_reset();
    check({26'h0, lo_oe_n, hi_oe_n, lo_inv_oe_n, hi_inv_oe_n, irq, wake_req}, 32'h3c);
    check({27'h0, avs_waitrequest, lo_o, hi_o, lo_inv, hi_inv}, 32'h13);
    check(avs_readdata, 32'h0);
    rd_chk(OFF_CTRL, 32'h0);
    rd_chk(OFF_LPST, 32'h0);
    rd_chk(OFF_IRQ_ST, 32'h0);
    wr(8'h30, 32'hffff_ffff);
    rd_chk(8'h30, RD_UNMAPPED);
  endtask : t_reset

  // Gating by wake enable, interrupt masking, wake from sleep
  task automatic t_wake();
    wr(OFF_CMP, 32'hffff_0002);
    wr(OFF_LPEN, 32'h1 << LP_INDEX);
    wr(OFF_IRQ_MASK, 32'h1);
    start({MODE_ONESHOT, 4'h1});
    repeat (20) @(posedge clock);
    check({31'h0, wake_req}, 32'h0);
    rd_chk(OFF_LPST, 32'h0);
    rd_chk(OFF_IRQ_ST, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    @(posedge clock);
    check({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_IRQ_ST, 32'h7);
    @(posedge clock);
    check({31'h0, irq}, 32'h0);
    sleep_req <= 1'b1;
    @(posedge clock);
    sleep_req <= 1'b0;
    @(posedge clock);
    check({31'h0, sys_clk_on}, 32'h0);
    start({MODE_ONESHOT, 4'h3});
    wait_wake(1'b1);
    repeat (2) @(posedge clock);
    check({31'h0, sys_clk_on}, 32'h1);
    rd_chk(OFF_WKFL, 32'h1);
    rd_chk(OFF_LPST, 32'h1 << LP_INDEX);
    rd_chk(OFF_IRQ_ST, 32'h5);
    check({31'h0, wake_req}, 32'h1);
    wr(OFF_LPST, 32'h3);
    @(posedge clock);
    check({31'h0, wake_req}, 32'h0);
    wr(OFF_WKFL, 32'h1);
    rd_chk(OFF_WKFL, 32'h0);
  endtask : t_wake

  // Every mode code: drivers only in output modes
  task automatic t_pins();
    logic [3:0] m;
    logic [3:0] e;
    for (int i = 0; i < 16; i++) begin
      m = i[3:0];
      e = (m == MODE_ONESHOT || m == MODE_CONT || m == MODE_COMPARE) ? 4'h0 : 4'hf;
      wr(OFF_CTRL, {24'h0, m, 4'hc});
      repeat (2) @(posedge clock);
      check({28'h0, lo_oe_n, hi_oe_n, lo_inv_oe_n, hi_inv_oe_n}, {28'h0, e});
      check({30'h0, lo_inv, hi_inv}, {30'h0, ~lo_o, ~hi_o});
    end
    start({MODE_CONT, 4'h1});
    wr(OFF_CTRL, {24'h0, MODE_COUNTER, 4'h1});
    rd(OFF_CTRL, rv);
    check({28'h0, rv[7:4]}, {28'h0, MODE_CONT});
    wr(OFF_CTRL, 32'h0);
  endtask : t_pins

  // Capture driven by the lower-half pin
  task automatic t_capture();
    wr(OFF_CMP, 32'hffff_ffff);
    start({MODE_CAPTURE, 4'h1});
    repeat (5) @(posedge clock);
    rd_chk(OFF_CAP, 32'h0);
    pin_lo <= 1'b1;
    repeat (8) @(posedge clock);
    rd(OFF_CAP, rv);
    check({31'h0, rv[15:0] != 16'h0}, 32'h1);
    wr(OFF_CTRL, 32'h0);
  endtask : t_capture

  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_wake();
    t_pins();
    t_capture();
    results();
  end
endmodule : tb_top
